// ===== hw/iox_pkg.sv
// Package: register map, reset values and states of the I/O expander block
package iox_pkg;
   localparam logic [7:0] ADDR_IN0 = 8'h00;
   localparam logic [7:0] ADDR_IN1 = 8'h01;
   localparam logic [7:0] ADDR_OUT0 = 8'h02;
   localparam logic [7:0] ADDR_OUT1 = 8'h03;
   localparam logic [7:0] ADDR_POL0 = 8'h04;
   localparam logic [7:0] ADDR_POL1 = 8'h05;
   localparam logic [7:0] ADDR_DIR0 = 8'h06;
   localparam logic [7:0] ADDR_DIR1 = 8'h07;
   localparam logic [7:0] ADDR_DRV0 = 8'h08;
   localparam logic [7:0] ADDR_DRV1 = 8'h09;
   localparam logic [7:0] ADDR_FEN0 = 8'h0a;
   localparam logic [7:0] ADDR_FEN1 = 8'h0b;
   localparam logic [7:0] RST_DIR = 8'hff;
   localparam logic [7:0] RST_DRV = 8'hff;
   localparam logic [7:0] RST_FEN = 8'h00;
   localparam logic [7:0] RST_OUT = 8'hff;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam int PORT_W = 8;
   localparam int SYNC_W = 16;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SETTLE = 3'b010,
      ST_RUN = 3'b100
   } iox_state_t;
endpackage : iox_pkg

// ===== hw/iox_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module iox_sync #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } iox_sync_st_t;
   iox_sync_st_t s_reg;
   iox_sync_st_t s_next;

   // First stage is read only by the second stage
   always_comb begin
      s_next = s_reg;
      s_next.meta = d;
      s_next.stable = s_reg.meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.stable;
endmodule : iox_sync

// ===== hw/iox_port_ctrl.sv
// Pin direction, drive mode and output anomaly control of a 16-pin expander
//
// Overview of operation
// R01: Port 0 direction bit one makes pin an input, zero an output.
// R02: Port 1 direction register controls its eight pins the same way.
// R03: Port 0 direction register resets to all ones, pins start as inputs.
// R04: Output drive is push-pull when mode bit is one, open-drain if zero.
// R05: Both drive-mode registers reset to all ones.
// R06: Enabled port 0 pins interrupt when sensed level differs from command.
// R07: Anomaly interrupt withdraws once sensed level agrees with command again.
// R08: Input register read clears anomaly once; recurrence then stays silent.
// R09: Anomaly enable bit zero gives no anomaly interrupt for that pin.
// R10: Any input change raises the interrupt regardless of anomaly enables.
// R11: Anomaly-enable registers reset to all zeros.
// R12: Output register bits only drive pins set as outputs.
// R13: Input registers return sensed levels always; writes to them ignored.
// R14: Port 1 anomaly enable behaves as port 0 against port 1 output.
// R15: Interrupt line is active low, held while any source is pending.
// R16: Drive-mode bits ignored for input pins; those stay high impedance.
//
// Register map (offset, reset):
//   0x00 port 0 input levels, read only
//   0x01 port 1 input levels, read only
//   0x02 port 0 output levels, ff
//   0x03 port 1 output levels, ff
//   0x04 port 0 read inversion, 00
//   0x05 port 1 read inversion, 00
//   0x06 port 0 direction, ff (one = input)
//   0x07 port 1 direction, ff
//   0x08 port 0 drive mode, ff (one = push-pull)
//   0x09 port 1 drive mode, ff
//   0x0a port 0 anomaly enable, 00
//   0x0b port 1 anomaly enable, 00
//   Other offsets read as zero, writes dropped
//
// Timing on link_clk:
//   Read data one edge after the read strobe, zero otherwise
//   Pins follow a write two edges later
//   Pin change to interrupt takes three to four edges
//   Detection starts three edges after reset release
//
// Limitations:
//   Inversion applies to read data only, never to anomaly compare
//   Input change covers pins set as inputs only; outputs use anomaly
//   Once spent, an anomaly stays silent until its enable is cleared
//   A change in the same cycle as a read clear wins over the clear
//   Open-drain pins driving high are released, not driven

`timescale 1ns/1ps
module iox_port_ctrl
   import iox_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   output logic interrupt_line_n
);
   // Host register side and pin logic both run on link_clk; the pin
   // levels arrive asynchronously and are synchronised there.
   typedef struct packed {
      logic [7:0] port0_direction_bits;
      logic [7:0] port1_direction_bits;
      logic [7:0] port0_drive_select;
      logic [7:0] port1_drive_select;
      logic [7:0] port0_fault_enable_bits;
      logic [7:0] port1_fault_enable_bits;
      logic [7:0] port0_commanded_level;
      logic [7:0] port1_commanded_level;
      logic [7:0] pol0;
      logic [7:0] pol1;
      logic [15:0] last_seen;
      logic [15:0] fault_spent;
      logic [15:0] fault_seen;
      logic [1:0] change_pend;
      logic [7:0] rdata;
      logic [15:0] out;
      logic [15:0] oe;
      logic irq_n;
      logic warm;
      iox_state_t state;
   } iox_st_t;

   iox_st_t r_reg;
   iox_st_t r_next;
   logic [15:0] sensed;
   logic [7:0] port0_sensed_level;

   // Pin levels come from outside, so two flops before any use
   iox_sync #(.W(SYNC_W)) u_sync (
      .clk(link_clk),
      .rst(rst),
      .d(pin_in),
      .q(sensed)
   );

   assign port0_sensed_level = sensed[7:0];

   // Drive enable: push-pull drives both levels, open-drain only low
   function automatic logic [7:0] drive_en(input logic [7:0] dir,
                                            input logic [7:0] mode,
                                            input logic [7:0] lvl);
      drive_en = ~dir & (mode | ~lvl);
   endfunction : drive_en

   // Mismatch between sensed pin and commanded level on enabled outputs
   function automatic logic [7:0] mismatch(input logic [7:0] en,
                                            input logic [7:0] dir,
                                            input logic [7:0] sns,
                                            input logic [7:0] cmd);
      mismatch = en & ~dir & (sns ^ cmd);
   endfunction : mismatch

   // Changed levels on pins set as inputs only
   function automatic logic changed(input logic [7:0] sns,
                                    input logic [7:0] last,
                                    input logic [7:0] dir);
      changed = |((sns ^ last) & dir);
   endfunction : changed

   // Level presented on a port; zero where the pin is an input
   function automatic logic [7:0] port_out(input logic [7:0] dir,
                                           input logic [7:0] lvl);
      port_out = lvl & ~dir;
   endfunction : port_out

   // Register update, anomaly tracking and pin drive
   always_comb begin
      logic [7:0] mm0;
      logic [7:0] mm1;
      logic [1:0] chg;
      logic [1:0] rd_in;
      logic [15:0] live;
      live = '0;
      mm0 = '0;
      mm1 = '0;
      chg = '0;
      rd_in = '0;
      r_next = r_reg;
      case (r_reg.state)
         ST_IDLE: begin
            // Extra edge so both synchroniser stages hold real levels
            r_next.warm = 1'b1;
            if (r_reg.warm) begin
               r_next.state = ST_SETTLE;
            end else begin
               r_next.state = ST_IDLE;
            end
         end
         ST_SETTLE: begin
            // Take the synchronised pin levels as the input-change baseline
            r_next.last_seen = sensed;
            r_next.state = ST_RUN;
         end
         ST_RUN: begin
            r_next.state = ST_RUN;
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase

      // Register writes; input registers are read-only
      if (reg_wr) begin
         case (reg_addr)
            ADDR_OUT0: r_next.port0_commanded_level = reg_wdata;
            ADDR_OUT1: r_next.port1_commanded_level = reg_wdata;
            ADDR_POL0: r_next.pol0 = reg_wdata;
            ADDR_POL1: r_next.pol1 = reg_wdata;
            ADDR_DIR0: r_next.port0_direction_bits = reg_wdata; // R01
            ADDR_DIR1: r_next.port1_direction_bits = reg_wdata; // R02
            ADDR_DRV0: r_next.port0_drive_select = reg_wdata; // R04
            ADDR_DRV1: r_next.port1_drive_select = reg_wdata; // R04
            ADDR_FEN0: r_next.port0_fault_enable_bits = reg_wdata;
            ADDR_FEN1: r_next.port1_fault_enable_bits = reg_wdata; // R14
            default: r_next.port0_commanded_level =
               r_reg.port0_commanded_level; // R13
         endcase
      end

      // Read data; input registers show sensed level in any direction
      r_next.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_IN0: r_next.rdata = port0_sensed_level ^ r_reg.pol0; // R13
            ADDR_IN1: r_next.rdata = sensed[15:8] ^ r_reg.pol1; // R13
            ADDR_OUT0: r_next.rdata = r_reg.port0_commanded_level;
            ADDR_OUT1: r_next.rdata = r_reg.port1_commanded_level;
            ADDR_POL0: r_next.rdata = r_reg.pol0;
            ADDR_POL1: r_next.rdata = r_reg.pol1;
            ADDR_DIR0: r_next.rdata = r_reg.port0_direction_bits;
            ADDR_DIR1: r_next.rdata = r_reg.port1_direction_bits;
            ADDR_DRV0: r_next.rdata = r_reg.port0_drive_select;
            ADDR_DRV1: r_next.rdata = r_reg.port1_drive_select;
            ADDR_FEN0: r_next.rdata = r_reg.port0_fault_enable_bits;
            ADDR_FEN1: r_next.rdata = r_reg.port1_fault_enable_bits;
            default: r_next.rdata = 8'h00;
         endcase
         rd_in[0] = (reg_addr == ADDR_IN0);
         rd_in[1] = (reg_addr == ADDR_IN1);
      end

      // Anomaly detection, only on enabled output pins
      mm0 = mismatch(r_reg.port0_fault_enable_bits,
                     r_reg.port0_direction_bits, port0_sensed_level,
                     r_reg.port0_commanded_level); // R06 R09
      mm1 = mismatch(r_reg.port1_fault_enable_bits,
                     r_reg.port1_direction_bits, sensed[15:8],
                     r_reg.port1_commanded_level); // R14 R09
      if (r_reg.state != ST_RUN) begin
         mm0 = '0;
         mm1 = '0;
      end
      r_next.fault_seen = {mm1, mm0};
      // A read retires the current anomaly for good on that port;
      // the spent flag only drops when the pin's enable is cleared, so a
      // recurrence is still blocked since spent bits stay latched.
      if (rd_in[0]) begin
         r_next.fault_spent[7:0] = r_reg.fault_spent[7:0] | mm0; // R08
      end
      if (rd_in[1]) begin
         r_next.fault_spent[15:8] = r_reg.fault_spent[15:8] | mm1; // R08
      end
      // Disabling a pin's enable rearms its once-only clear
      r_next.fault_spent = r_next.fault_spent &
         {r_reg.port1_fault_enable_bits, r_reg.port0_fault_enable_bits};

      // Input change detection; the new change wins over a read clear
      if (r_reg.state == ST_RUN) begin
         chg[0] = changed(port0_sensed_level,
                          r_reg.last_seen[7:0],
                          r_reg.port0_direction_bits);
         chg[1] = changed(sensed[15:8],
                          r_reg.last_seen[15:8],
                          r_reg.port1_direction_bits);
         r_next.last_seen = sensed;
      end
      r_next.change_pend = (r_reg.change_pend & ~rd_in) | chg; // R10

      // Interrupt: any pending change or live, unspent anomaly
      live = r_next.fault_seen & ~r_next.fault_spent; // R07
      r_next.irq_n = ~(|r_next.change_pend | |live); // R15

      // Pin drive; inputs stay high impedance whatever the mode
      r_next.oe = {drive_en(r_reg.port1_direction_bits,
                            r_reg.port1_drive_select,
                            r_reg.port1_commanded_level),
                   drive_en(r_reg.port0_direction_bits,
                            r_reg.port0_drive_select,
                            r_reg.port0_commanded_level)}; // R16 R04
      r_next.out = {port_out(r_reg.port1_direction_bits,
                             r_reg.port1_commanded_level),
                    port_out(r_reg.port0_direction_bits,
                             r_reg.port0_commanded_level)}; // R12
   end

   // Constant reset values only
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
         r_reg.port0_direction_bits <= RST_DIR; // R03
         r_reg.port1_direction_bits <= RST_DIR;
         r_reg.port0_drive_select <= RST_DRV; // R05
         r_reg.port1_drive_select <= RST_DRV; // R05
         r_reg.port0_fault_enable_bits <= RST_FEN; // R11
         r_reg.port1_fault_enable_bits <= RST_FEN; // R11
         r_reg.port0_commanded_level <= RST_OUT;
         r_reg.port1_commanded_level <= RST_OUT;
         r_reg.pol0 <= RST_POL;
         r_reg.pol1 <= RST_POL;
         r_reg.irq_n <= 1'b1;
         r_reg.state <= ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata = r_reg.rdata;
   assign pin_out = r_reg.out;
   assign pin_oe = r_reg.oe;
   assign interrupt_line_n = r_reg.irq_n;

   // clk is kept for system integration; all state is on link_clk
   logic clk_unused;
   assign clk_unused = clk;
endmodule : iox_port_ctrl

// ===== tb/iox_port_ctrl_assertions.sv
// Checker: register answers, pin drive timing and interrupt behaviour
`timescale 1ns/1ps
module iox_port_ctrl_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic interrupt_line_n
);
   import iox_pkg::*;
   logic [1:0] live_reg;
   default clocking @(posedge link_clk); endclocking
   default disable iff (rst);
   // Detection only arms a few edges after reset, so wait for it
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         live_reg <= 2'd0;
      end else if (live_reg != 2'd3) begin
         live_reg <= live_reg + 2'd1;
      end
   end
   sequence s_quiet;
      !reg_wr && !reg_rd && $stable(pin_in);
   endsequence
   sequence s_read(a);
      reg_rd && reg_addr == a && $stable(pin_in);
   endsequence
   sequence s_calm;
      !reg_wr && !reg_rd && $stable(pin_oe);
   endsequence
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_unmapped;
      reg_rd && reg_addr > ADDR_FEN1 |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_dir0;
      reg_wr && reg_addr == ADDR_DIR0 |-> ##2
         (pin_oe[7:0] & $past(reg_wdata, 2)) == 8'h00;
   endproperty
   a_dir0: assert property (p_dir0) else $error("port 0 input driven");
   property p_dir1;
      reg_wr && reg_addr == ADDR_DIR1 |-> ##2
         (pin_oe[15:8] & $past(reg_wdata, 2)) == 8'h00;
   endproperty
   a_dir1: assert property (p_dir1) else $error("port 1 input driven");
   property p_hold;
      !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(pin_oe) && $stable(pin_out);
   endproperty
   a_hold: assert property (p_hold) else $error("pins moved unasked");
   property p_quiet;
      live_reg == 2'd3 && !reg_wr && !reg_rd && $stable(pin_in) ##1
         s_quiet [*5] |-> $stable(interrupt_line_n);
   endproperty
   a_quiet: assert property (p_quiet) else $error("irq moved unasked");
   property p_change;
      live_reg == 2'd3 && $stable(pin_oe) && $changed(pin_in & ~pin_oe)
         ##1 s_calm [*5] |-> !interrupt_line_n;
   endproperty
   a_change: assert property (p_change) else $error("no change irq");
   property p_clear;
      s_quiet [*6] ##1 s_read(ADDR_IN0) ##1 s_quiet ##1 s_read(ADDR_IN1)
         ##1 s_quiet [*3] |-> interrupt_line_n;
   endproperty
   a_clear: assert property (p_clear) else $error("irq not cleared");
endmodule : iox_port_ctrl_chk
bind iox_port_ctrl iox_port_ctrl_chk u_chk (.clk(clk), .rst(rst),
   .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .interrupt_line_n(interrupt_line_n));

// ===== tb/iox_host.sv
// Host register master model on the strobe interface
`timescale 1ns/1ps
module iox_host (
   input wire logic link_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle bus from time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Strobe held a full cycle; stale fields scrambled so none leans on them
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge link_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge link_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge link_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge link_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      v = reg_rdata;
   endtask : rd
endmodule : iox_host

// ===== tb/tb.sv
// Testbench: register map, pin drive, input-change and anomaly interrupt
`timescale 1ns/1ps
module tb;
   import iox_pkg::*;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr, reg_rd, interrupt_line_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [7:0] dir0, dir1, drv0, drv1, out0, out1;
   logic [15:0] pin_in, pin_out, pin_oe, e;
   logic [15:0] ext = 16'hffff;
   logic [15:0] flt = 16'h0000;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   // Driven pins show the level with injected faults, others the outside
   assign pin_in = (pin_oe & (pin_out ^ flt)) | (~pin_oe & ext);
   initial forever #4 clk = ~clk;
   initial begin
      #5;
      forever #24 link_clk = ~link_clk;
   end
   iox_port_ctrl uut (.clk(clk), .rst(rst), .link_clk(link_clk),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe),
      .interrupt_line_n(interrupt_line_n));
   iox_host host (.link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // Open-drain drives only a low, so a high there is released
   function automatic logic [15:0] oe_exp();
      return ~{dir1, dir0} & ({drv1, drv0} | ~{out1, out0});
   endfunction : oe_exp
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      host.rd(a, d);
      chk({8'h00, d}, {8'h00, x});
   endtask : rdc
   task automatic irq(input logic v);
      chk({15'h0000, interrupt_line_n}, {15'h0000, v});
   endtask : irq
   task automatic settle;
      repeat (6) @(negedge link_clk);
   endtask : settle
   task automatic cfg(input logic [47:0] v);
      {dir0, dir1, drv0, drv1, out0, out1} = v;
      host.wr(ADDR_OUT0, out0);
      host.wr(ADDR_OUT1, out1);
      host.wr(ADDR_DRV0, drv0);
      host.wr(ADDR_DRV1, drv1);
      host.wr(ADDR_DIR0, dir0);
      host.wr(ADDR_DIR1, dir1);
      settle;
   endtask : cfg
   // Both input registers read back to back clear pending sources
   task automatic clr;
      settle;
      host.rd(ADDR_IN0, d);
      host.rd(ADDR_IN1, d);
      settle;
   endtask : clr
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   // Hang guard, far above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         tally_and_finish;
      end
   end
   initial begin
      void'($urandom(32'he4f66f83));
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rdc(ADDR_DIR0, RST_DIR);
      rdc(ADDR_DIR1, RST_DIR);
      rdc(ADDR_DRV0, RST_DRV);
      rdc(ADDR_DRV1, RST_DRV);
      rdc(ADDR_FEN0, RST_FEN);
      rdc(ADDR_FEN1, RST_FEN);
      chk(pin_oe, 16'h0000);
      host.wr(ADDR_IN0, 8'h00);
      rdc(ADDR_IN0, ext[7:0]);
      host.wr(ADDR_POL0, 8'h0f);
      rdc(ADDR_IN0, ext[7:0] ^ 8'h0f);
      host.wr(ADDR_POL0, RST_POL);
      rdc(8'h0c, 8'h00);
      $display("test reset_map done");
      // Random direction, mode and level, corners first
      for (int i = 0; i < 40; i++) begin
         cfg(i == 0 ? 48'h0 : i == 1 ? 48'h0000ffff5a3c : {$urandom, 16'($urandom)});
         e = oe_exp();
         chk(pin_oe, e);
         chk(pin_out & e, {out1, out0} & e);
         rdc(ADDR_IN1,
             8'(((e & {out1, out0}) | (~e & ext)) >> 8));
      end
      $display("test drive done");
      cfg(48'hffffffffffff);
      clr;
      irq(1'b1);
      ext[3] = 1'b0;
      ext[12] = 1'b0;
      settle;
      irq(1'b0);
      host.rd(ADDR_IN0, d);
      settle;
      irq(1'b0);
      host.rd(ADDR_IN1, d);
      settle;
      irq(1'b1);
      $display("test input_change done");
      cfg(48'h00ffffffa5ff);
      host.wr(ADDR_FEN0, 8'h01);
      clr;
      flt[0] = 1'b1;
      settle;
      irq(1'b0);
      flt[0] = 1'b0;
      settle;
      irq(1'b1);
      flt[0] = 1'b1;
      settle;
      host.rd(ADDR_IN0, d);
      settle;
      irq(1'b1);
      flt[0] = 1'b0;
      settle;
      flt[0] = 1'b1;
      settle;
      irq(1'b1);
      host.wr(ADDR_FEN0, 8'h00);
      flt[1] = 1'b1;
      settle;
      irq(1'b1);
      $display("test anomaly0 done");
      cfg(48'h0000ffffa55a);
      host.wr(ADDR_FEN1, 8'h80);
      clr;
      flt[15] = 1'b1;
      settle;
      irq(1'b0);
      flt[15] = 1'b0;
      settle;
      irq(1'b1);
      $display("test anomaly1 done");
      tally_and_finish;
   end
endmodule : tb
